// >>> src/acq_window_vertical_sequencer.sv
// Acquisition windows, capture gate and vertical control table sequencer
//
// Functional notes
// - Horizontal window lasts exactly the programmed active clocks per line.
// - Horizontal start comes from table start bit or line-valid start.
// - Horizontal start delayed 0 to 7 clocks by trim setting.
// - Horizontal start advanced 0 to 7 clocks by advance setting.
// - Vertical window lasts programmed number of horizontal window periods.
// - Vertical start comes from table start bit or frame-valid start.
// - Capture only while both windows are active.
// - Vertical counter is 17 bits and addresses the vertical table.
// - Load control forces the vertical counter to 8000h.
// - Reset control forces the vertical counter to zero.
// - Reset control wins over load when both occur together.
// - Load wins over a table clear pulse in the same cycle.
// - Inhibited counter holds; load and reset still act.
// - Free-running counter scans ascending and wraps through the table.
// - Table entry bits: start, clear, load enable, irq, four waveforms.
// - Frame-valid edge loads only while entry load enable is set.
// - Entry interrupt bit raises an interrupt request.
// - Entry clear bit resets counter when table reset source selected.
// - Counter advances once per line on the end-of-line event.
// - At zero the counter keeps counting or waits for trigger.
// - Increment stops when counter reaches 7FF0h.
// - While stuck, hold 7FF0h until frame-valid, then load 8000h.
// - Stick behaviour enabled by the stick release setting.
// - Frame-valid load edge polarity chosen by edge select setting; vertical window start always uses the rising edge.
`timescale 1ns/1ps
`include "acq_window_regs.svh"

module acq_window_vertical_sequencer (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   input  wire logic        i_line_valid_in,
   input  wire logic        i_frame_valid_in,
   input  wire logic        i_trigger,
   input  wire logic        i_htable_window_start_bit,
   input  wire logic        i_htable_line_end,
   input  wire logic        i_horiz_window_start_sel,
   input  wire logic        i_vert_window_start_sel,
   input  wire logic [16:0] i_active_clocks_per_line,
   input  wire logic [16:0] i_active_lines_per_frame,
   input  wire logic [2:0]  i_horiz_trim,
   input  wire logic [2:0]  i_horiz_advance,
   input  wire logic        i_vert_zero_release_sel,
   input  wire logic        i_vert_stick_release_sel,
   input  wire logic        i_frame_valid_edge_sel,
   input  wire logic        i_vert_counter_clear,
   input  wire logic        i_vert_table_reset_sel,
   input  wire logic        i_vtable_wr_en,
   input  wire logic [16:0] i_vtable_wr_addr,
   input  wire logic [7:0]  i_vtable_wr_data,
   output logic             o_horiz_window,
   output logic             o_vert_window,
   output logic             o_capture_en,
   output logic [16:0]      o_vert_counter,
   output logic             o_vert_stuck,
   output logic             o_vtable_irq_req,
   output logic             o_vtable_gp_wave0,
   output logic             o_vtable_gp_wave1,
   output logic             o_vtable_gp_wave2,
   output logic             o_vtable_gp_wave3
);

   // =======================================================================
   // Pin synchronisers: line valid, frame valid, trigger
   // =======================================================================
   logic [2:0] pin_async;
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic [2:0] sync3_reg;

   assign pin_async = {i_trigger, i_frame_valid_in, i_line_valid_in};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge i_clk_sys) begin
            if (i_reset) begin
               sync1_reg[g] <= 1'b0;
               sync2_reg[g] <= 1'b0;
               sync3_reg[g] <= 1'b0;
            end else begin
               sync1_reg[g] <= pin_async[g];
               sync2_reg[g] <= sync1_reg[g];
               sync3_reg[g] <= sync2_reg[g];
            end
         end
      end
   endgenerate

   logic lv_rise;
   logic fv_rise;
   logic fv_fall;
   logic fv_level;
   logic trig_level;

   assign lv_rise    = sync2_reg[0] & ~sync3_reg[0];
   assign fv_rise    = sync2_reg[1] & ~sync3_reg[1];
   assign fv_fall    = ~sync2_reg[1] & sync3_reg[1];
   assign fv_level   = sync2_reg[1];
   assign trig_level = sync2_reg[2];

   // =======================================================================
   // Vertical control table memory
   // =======================================================================
   logic [7:0] vert_table [0:`ACQ_VTABLE_DEPTH-1];
   logic [7:0] vtable_entry_reg;
   logic [7:0] vtable_entry_prev_reg;
   acq_window_pkg::vert_counter_t vert_counter_reg;
   acq_window_pkg::vert_counter_t vert_counter_next;

   // host path only writes; the sequencer only reads
   always_ff @(posedge i_clk_sys) begin
      if (i_vtable_wr_en) begin
         vert_table[i_vtable_wr_addr] <= i_vtable_wr_data;
      end
   end

   // read at next address so the entry always matches the counter
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         vtable_entry_reg      <= 8'h00;
         vtable_entry_prev_reg <= 8'h00;
      end else begin
         vtable_entry_reg      <= vert_table[vert_counter_next];
         vtable_entry_prev_reg <= vtable_entry_reg;
      end
   end

   // =======================================================================
   // Vertical counter control
   // =======================================================================
   logic fv_edge;
   logic stuck;
   logic zero_wait;
   logic load_ev;
   logic table_clear;
   acq_window_pkg::vcnt_op_t vop;

   // edge polarity select: 0 rising, 1 falling
   assign fv_edge = i_frame_valid_edge_sel ? fv_fall : fv_rise;

   assign stuck = i_vert_stick_release_sel &&
                  (vert_counter_reg == `ACQ_VCNT_STICK_VAL);

   // hold at zero until trigger when zero release is selected
   assign zero_wait = i_vert_zero_release_sel && !trig_level &&
                      (vert_counter_reg == `ACQ_VCNT_RESET_VAL);

   // masked edge load, or release of a stuck counter
   assign load_ev = (fv_edge && vtable_entry_reg[`ACQ_VT_LOAD_EN_BIT]) ||
                    (stuck && fv_level);

   // table clear acts on the line clock when selected
   assign table_clear = i_vert_table_reset_sel && i_htable_line_end &&
                        vtable_entry_reg[`ACQ_VT_CLEAR_BIT];

   // clear control > load > table clear > increment
   always_comb begin
      if (i_vert_counter_clear) begin
         vop = acq_window_pkg::VOP_CLEAR;
      end else if (load_ev) begin
         vop = acq_window_pkg::VOP_LOAD;
      end else if (table_clear) begin
         vop = acq_window_pkg::VOP_CLEAR;
      end else if (i_htable_line_end && !stuck && !zero_wait) begin
         // one step per line unless inhibited
         vop = acq_window_pkg::VOP_INC;
      end else begin
         vop = acq_window_pkg::VOP_HOLD;
      end
   end

   always_comb begin
      unique case (vop)
         acq_window_pkg::VOP_HOLD:  vert_counter_next = vert_counter_reg;
         // natural 17-bit wrap covers the whole table
         acq_window_pkg::VOP_INC:   vert_counter_next =
                                       vert_counter_reg + `ACQ_VCNT_ONE;
         acq_window_pkg::VOP_LOAD:  vert_counter_next = `ACQ_VCNT_LOAD_VAL;
         acq_window_pkg::VOP_CLEAR: vert_counter_next = `ACQ_VCNT_RESET_VAL;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         vert_counter_reg <= `ACQ_VCNT_RESET_VAL;
      end else begin
         vert_counter_reg <= vert_counter_next;
      end
   end

   // =======================================================================
   // Horizontal start path with trim and advance
   // =======================================================================
   // Advance cannot precede its cause, so every start passes a fixed base
   // latency; the capture gate therefore lines up with video that is
   // delayed by the same base amount.
   logic                   h_start_src;
   logic                   h_src_prev_reg;
   logic                   h_start_ev;
   logic [14:0]            start_pipe_reg;
   logic [15:0]            start_taps;
   logic [3:0]             tap_sel;
   logic                   h_start_tapped;

   assign h_start_src = i_horiz_window_start_sel ?
                        i_htable_window_start_bit : sync2_reg[0];

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         h_src_prev_reg <= 1'b0;
      end else begin
         h_src_prev_reg <= i_htable_window_start_bit;
      end
   end

   assign h_start_ev = i_horiz_window_start_sel ?
                       (h_start_src & ~h_src_prev_reg) : lv_rise;

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         start_pipe_reg <= 15'h0000;
      end else begin
         start_pipe_reg <= {start_pipe_reg[13:0], h_start_ev};
      end
   end

   // tap = base + trim - advance, range 0 to 14
   assign tap_sel = `ACQ_START_BASE_DLY + {1'b0, i_horiz_trim}
                    - {1'b0, i_horiz_advance};
   assign start_taps     = {start_pipe_reg, h_start_ev};
   assign h_start_tapped = start_taps[tap_sel];

   // =======================================================================
   // Horizontal window
   // =======================================================================
   logic [16:0] h_left_reg;
   logic        hwin_reg;

   // window open for exactly the programmed number of clocks
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         hwin_reg   <= 1'b0;
         h_left_reg <= 17'h00000;
      end else if (h_start_tapped && !hwin_reg) begin
         hwin_reg   <= (i_active_clocks_per_line != 17'h00000);
         h_left_reg <= i_active_clocks_per_line;
      end else if (hwin_reg) begin
         hwin_reg   <= (h_left_reg != 17'h00001);
         h_left_reg <= h_left_reg - 17'h00001;
      end
   end

   logic hwin_end;
   assign hwin_end = hwin_reg && (h_left_reg == 17'h00001);

   // =======================================================================
   // Vertical window
   // =======================================================================
   logic        v_start_ev;
   logic [16:0] v_left_reg;
   logic        vwin_reg;

   assign v_start_ev = i_vert_window_start_sel ?
      (vtable_entry_reg[`ACQ_VT_START_BIT] &
       ~vtable_entry_prev_reg[`ACQ_VT_START_BIT]) : fv_rise;

   // window counts completed horizontal window periods
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         vwin_reg   <= 1'b0;
         v_left_reg <= 17'h00000;
      end else if (v_start_ev && !vwin_reg) begin
         vwin_reg   <= (i_active_lines_per_frame != 17'h00000);
         v_left_reg <= i_active_lines_per_frame;
      end else if (vwin_reg && hwin_end) begin
         vwin_reg   <= (v_left_reg != 17'h00001);
         v_left_reg <= v_left_reg - 17'h00001;
      end
   end

   // =======================================================================
   // Outputs
   // =======================================================================
   // capture gate
   assign o_capture_en   = hwin_reg & vwin_reg;
   assign o_horiz_window = hwin_reg;
   assign o_vert_window  = vwin_reg;
   assign o_vert_counter = vert_counter_reg;
   assign o_vert_stuck   = stuck;
   // entry bits drive irq and waveforms
   assign o_vtable_irq_req  = vtable_entry_reg[`ACQ_VT_IRQ_BIT];
   assign o_vtable_gp_wave0 = vtable_entry_reg[`ACQ_VT_GP0_BIT];
   assign o_vtable_gp_wave1 = vtable_entry_reg[`ACQ_VT_GP1_BIT];
   assign o_vtable_gp_wave2 = vtable_entry_reg[`ACQ_VT_GP2_BIT];
   assign o_vtable_gp_wave3 = vtable_entry_reg[`ACQ_VT_GP3_BIT];

   // =======================================================================
   // Assertions
   // =======================================================================
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   logic [16:0] h_len_reg;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         h_len_reg <= 17'h00000;
      end else if (hwin_reg) begin
         h_len_reg <= h_len_reg + 17'h00001;
      end else begin
         h_len_reg <= 17'h00000;
      end
   end

   sequence s_clear_req;
      i_vert_counter_clear;
   endsequence

   sequence s_load_req;
      load_ev && !i_vert_counter_clear;
   endsequence

   sequence s_plain_step;
      i_htable_line_end && !i_vert_counter_clear && !load_ev &&
      !table_clear && !stuck && !zero_wait;
   endsequence

   clear_zero_a: assert property (s_clear_req |=>
      o_vert_counter == 17'h0)
      else $error("Counter not cleared by reset control");

   load_value_a: assert property (s_load_req |=>
      o_vert_counter == 17'h08000)
      else $error("Counter not loaded with 8000h");

   line_step_a: assert property (s_plain_step |=>
      o_vert_counter == $past(o_vert_counter) + 17'h00001)
      else $error("Counter did not advance by one");

   stick_hold_a: assert property (stuck && !fv_level &&
      !i_vert_counter_clear && !load_ev && !table_clear |=>
      o_vert_counter == 17'h07ff0)
      else $error("Stuck counter moved without frame valid");

   zero_wait_a: assert property (zero_wait && !i_vert_counter_clear &&
      !load_ev |=> o_vert_counter == 17'h00000)
      else $error("Counter left zero without trigger");

   hwin_len_a: assert property ($fell(hwin_reg) |->
      h_len_reg == $past(h_left_reg, 1) + $past(h_len_reg, 1) - 17'h0)
      else $error("Horizontal window length wrong");

   vwin_open_a: assert property (v_start_ev && !vwin_reg &&
      i_active_lines_per_frame != 17'h0 |=> vwin_reg)
      else $error("Vertical window did not open");

   capture_gate_a: assert property ($rose(o_capture_en) |->
      o_horiz_window && o_vert_window)
      else $error("Capture outside the windows");

   htable_window_start_bit_dly_a: assert property (h_start_ev && tap_sel == 4'h7 &&
      !hwin_reg ##7 !hwin_reg && $stable(tap_sel) &&
      i_active_clocks_per_line != 17'h0 |=> hwin_reg)
      else $error("Horizontal start latency wrong");

endmodule : acq_window_vertical_sequencer

// >>> pkg/acq_window_regs.svh
// Constants for the acquisition window and vertical sequencer block
`ifndef ACQ_WINDOW_REGS_SVH
`define ACQ_WINDOW_REGS_SVH

// ==========================================================================
// Widths
// ==========================================================================
`define ACQ_COUNT_W          17
`define ACQ_VTABLE_W         8
`define ACQ_VTABLE_DEPTH     131072
`define ACQ_SHIFT_W          3
`define ACQ_PIPE_W           15
`define ACQ_TAP_W            4

// ==========================================================================
// Vertical counter values
// ==========================================================================
`define ACQ_VCNT_RESET_VAL   17'h00000
`define ACQ_VCNT_LOAD_VAL    17'h08000
`define ACQ_VCNT_STICK_VAL   17'h07ff0
`define ACQ_VCNT_ONE         17'h00001

// ==========================================================================
// Vertical table entry bit positions
// ==========================================================================
`define ACQ_VT_START_BIT     0
`define ACQ_VT_CLEAR_BIT     1
`define ACQ_VT_LOAD_EN_BIT   2
`define ACQ_VT_IRQ_BIT       3
`define ACQ_VT_GP0_BIT       4
`define ACQ_VT_GP1_BIT       5
`define ACQ_VT_GP2_BIT       6
`define ACQ_VT_GP3_BIT       7

// ==========================================================================
// Timing: fixed base latency of the horizontal start path, in clocks
// ==========================================================================
`define ACQ_START_BASE_DLY   4'h7

`endif

// >>> pkg/acq_window_pkg.sv
// Types shared by the acquisition window and vertical sequencer block
package acq_window_pkg;

   typedef logic [16:0] vert_counter_t;

   // Action taken by the vertical counter in one cycle
   typedef enum logic [1:0] {
      VOP_HOLD  = 2'b00,
      VOP_INC   = 2'b01,
      VOP_LOAD  = 2'b10,
      VOP_CLEAR = 2'b11
   } vcnt_op_t;

endpackage : acq_window_pkg

// >>> tb/cam_model.sv
// Camera model: a frame valid strobe around a burst of line valid strobes
`timescale 1ns/1ps
module cam_model (
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   input  wire logic       i_go,
   input  wire logic [3:0] i_lines,
   input  wire logic [5:0] i_len,
   output logic            o_frame_valid,
   output logic            o_line_valid
);
   logic [3:0] left_reg;
   logic [6:0] pos_reg;
   logic [6:0] end_pos;
   // Each line period is the line plus nine idle clocks
   assign end_pos = {1'b0, i_len} + 7'h08;
   always_ff @(posedge i_clk) begin
      if (i_reset || (i_go && !o_frame_valid)) begin
         o_frame_valid <= !i_reset;
         left_reg      <= i_lines;
         pos_reg       <= 7'h00;
      end else if (o_frame_valid) begin
         pos_reg <= (pos_reg == end_pos) ? 7'h00 : pos_reg + 7'h01;
         if (pos_reg == 7'h00)
            left_reg <= left_reg - 4'h1;
         if (pos_reg == 7'h00 && left_reg == 4'h0)
            o_frame_valid <= 1'b0;
      end
   end
   assign o_line_valid = o_frame_valid && pos_reg > 7'h03 &&
                         pos_reg < end_pos - 7'h04;
endmodule : cam_model

// >>> tb/acquisition_window_vertical_sequencer_tb_top.sv
// Self-checking bench for the acquisition window and vertical sequencer
`timescale 1ns/1ps
module acquisition_window_vertical_sequencer_tb_top;
   logic        clk_sys = 1'b0;
   logic        reset, go, htab_go, lend, trig, hsel, vsel, pc;
   logic        zrel, srel, esel, vclr, tsel, wr_en;
   logic        lv, fv, hwin, vwin, cap, stuck, irq;
   logic [3:0]  gp, n_lines;
   logic [5:0]  llen;
   logic [2:0]  trim, adv;
   logic [7:0]  wr_data, r;
   logic [7:0]  lfsr = 8'h54;
   logic [7:0]  tab [0:4];
   logic [16:0] active_clocks_per_line, active_lines_per_frame, wr_addr, vcnt;
   logic [19:0] note;
   logic [19:0] exp_q [$];
   int          err_count = 0;
   int          checks_done = 0;
   int          k, l, d, bad;
   int          base [0:1];
   event        look;

   always #2 clk_sys = ~clk_sys;

   cam_model i_cam (
      .i_clk(clk_sys), .i_reset(reset), .i_go(go), .i_lines(n_lines),
      .i_len(llen), .o_frame_valid(fv), .o_line_valid(lv)
   );

   acq_window_vertical_sequencer i_dut (
      .i_clk_sys(clk_sys), .i_reset(reset), .i_line_valid_in(lv),
      .i_frame_valid_in(fv), .i_trigger(trig),
      .i_htable_window_start_bit(htab_go), .i_htable_line_end(lend),
      .i_horiz_window_start_sel(hsel), .i_vert_window_start_sel(vsel),
      .i_active_clocks_per_line(active_clocks_per_line), .i_active_lines_per_frame(active_lines_per_frame),
      .i_horiz_trim(trim), .i_horiz_advance(adv),
      .i_vert_zero_release_sel(zrel), .i_vert_stick_release_sel(srel),
      .i_frame_valid_edge_sel(esel), .i_vert_counter_clear(vclr),
      .i_vert_table_reset_sel(tsel), .i_vtable_wr_en(wr_en),
      .i_vtable_wr_addr(wr_addr), .i_vtable_wr_data(wr_data),
      .o_horiz_window(hwin), .o_vert_window(vwin), .o_capture_en(cap),
      .o_vert_counter(vcnt), .o_vert_stuck(stuck),
      .o_vtable_irq_req(irq), .o_vtable_gp_wave0(gp[0]),
      .o_vtable_gp_wave1(gp[1]), .o_vtable_gp_wave2(gp[2]),
      .o_vtable_gp_wave3(gp[3])
   );

   task automatic check(input logic [16:0] seen, input logic [16:0] want);
      checks_done++;
      if (seen !== want) begin
         err_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
      end
   endtask : check

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   // Driver notes what an output should show now: 0 counter, 1 flags, 2 entry
   task automatic note_exp(input logic [2:0] s, input logic [16:0] v);
      exp_q.push_back({s, v});
      -> look;
   endtask : note_exp

   always @(look) begin
      while (exp_q.size() > 0) begin
         note = exp_q.pop_front();
         case (note[19:17])
            3'h0: check(vcnt, note[16:0]);
            3'h1: check({13'h0, hwin, vwin, cap, stuck}, note[16:0]);
            default: check({12'h0, gp, irq}, note[16:0]);
         endcase
      end
   end

   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction : rnd

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : tick

   task automatic pulse_end(input int n);
      repeat (n) begin
         lend = 1'b1;
         tick(1);
         lend = 1'b0;
         tick(1);
      end
   endtask : pulse_end

   task automatic clear_to(input int n);
      vclr = 1'b1;
      tick(1);
      vclr = 1'b0;
      pulse_end(n);
   endtask : clear_to

   task automatic frame(input int n);
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(n);
   endtask : frame

   // Pin loads pass a synchroniser, so the exact cycle is not pinned down
   task automatic wait_for(input logic [16:0] want);
      int i;
      for (i = 0; i < 100 && vcnt !== want; i++)
         tick(1);
      if (vcnt !== want) begin
         err_count++;
         $display("unexpected at %0t: counter wait ran out", $time);
         conclude();
      end
   endtask : wait_for

   task automatic hrun(input logic m, input logic src, input int t, a,
                       output int lat, output int dur);
      hsel = m;
      trim = 3'(t);
      adv = 3'(a);
      tick(2);
      htab_go = src;
      frame(0);
      for (lat = 0; lat < 40 && hwin !== 1'b1; lat++)
         tick(1);
      for (dur = 0; dur < 80 && hwin === 1'b1; dur++)
         tick(1);
      if (dur == 80 || (lat == 40 && m == src)) begin
         err_count++;
         $display("unexpected at %0t: window wait ran out", $time);
         conclude();
      end
      htab_go = 1'b0;
      tick(120);
   endtask : hrun

   initial begin
      {reset, go, htab_go, lend, trig, hsel, vsel} = 7'h40;
      {zrel, srel, esel, vclr, tsel, wr_en} = 6'h00;
      {active_clocks_per_line, active_lines_per_frame, wr_addr, wr_data} = 59'h0;
      {n_lines, llen, trim, adv} = {4'h1, 6'h30, 6'h00};
      tick(12);
      reset = 1'b0;
      tick(1);
      note_exp(3'h0, 17'h00000);
      note_exp(3'h1, 17'h00000);
      // Zero the table ahead of the counter while it climbs to the stick
      srel = 1'b1;
      wr_en = 1'b1;
      for (k = 0; k < 65520; k++) begin
         lend = (k % 2 == 0);
         wr_addr = 17'(k);
         tick(1);
         if (k == 199)
            note_exp(3'h0, 17'h00064);
      end
      wr_en = 1'b0;
      note_exp(3'h0, 17'h07ff0);
      note_exp(3'h1, 17'h00001);
      frame(0);
      wait_for(17'h08000);
      note_exp(3'h0, 17'h08000);
      note_exp(3'h1, 17'h00000);
      $display("done: stick");
      tick(150);
      r = rnd();
      tab[0] = {r[7:4], 4'hc};
      r = rnd();
      tab[1] = {r[7:4], 4'h0};
      tab[2] = 8'h04;
      tab[3] = 8'h01;
      tab[4] = 8'h02;
      wr_en = 1'b1;
      for (k = 0; k < 5; k++) begin
         wr_addr = 17'(k);
         wr_data = tab[k];
         tick(1);
      end
      wr_en = 1'b0;
      clear_to(0);
      note_exp(3'h0, 17'h00000);
      note_exp(3'h2, 17'(tab[0][7:3]));
      pulse_end(1);
      note_exp(3'h0, 17'h00001);
      note_exp(3'h2, 17'(tab[1][7:3]));
      frame(150);
      note_exp(3'h0, 17'h00001);
      pulse_end(1);
      frame(0);
      wait_for(17'h08000);
      note_exp(3'h0, 17'h08000);
      vclr = 1'b1;
      frame(0);
      bad = 0;
      repeat (20) begin
         tick(1);
         bad += (vcnt !== 17'h00000);
      end
      vclr = 1'b0;
      check(17'(bad), 17'h00000);
      tick(150);
      esel = 1'b1;
      clear_to(2);
      frame(20);
      note_exp(3'h0, 17'h00002);
      wait_for(17'h08000);
      note_exp(3'h0, 17'h08000);
      esel = 1'b0;
      tick(150);
      tsel = 1'b1;
      clear_to(4);
      pulse_end(1);
      note_exp(3'h0, 17'h00000);
      tsel = 1'b0;
      zrel = 1'b1;
      pulse_end(3);
      note_exp(3'h0, 17'h00000);
      trig = 1'b1;
      tick(4);
      pulse_end(2);
      note_exp(3'h0, 17'h00002);
      {trig, zrel} = 2'h0;
      $display("done: counter");
      {vsel, active_lines_per_frame, active_clocks_per_line} = {1'b1, 17'h00004, 17'h00010};
      pulse_end(1);
      tick(2);
      note_exp(3'h1, 17'h00004);
      n_lines = 4'h6;
      for (k = 0; k < 2; k++) begin
         frame(0);
         {bad, d, pc} = 65'h0;
         repeat (500) begin
            tick(1);
            d += (cap === 1'b1 && pc !== 1'b1);
            bad += (cap !== (hwin & vwin));
            pc = cap;
         end
         check(17'(d), 17'h00004);
         check(17'(bad), 17'h00000);
         note_exp(3'h1, 17'h00000);
         vsel = 1'b0;
      end
      $display("done: vertical window");
      {n_lines, active_lines_per_frame} = {4'h1, 17'h00000};
      hrun(1'b0, 1'b0, 0, 0, base[0], d);
      hrun(1'b1, 1'b1, 0, 0, base[1], d);
      check(17'(d), active_clocks_per_line);
      for (k = 0; k < 8; k++) begin
         r = rnd();
         active_clocks_per_line = {12'h000, r[4:0]} + 17'h00005;
         hrun(r[7], r[7], k, 7 - k, l, d);
         check(17'(l), 17'(base[r[7]] + 2 * k - 7));
         check(17'(d), active_clocks_per_line);
      end
      hrun(1'b1, 1'b0, 0, 0, l, d);
      check(17'(d), 17'h00000);
      $display("done: horizontal window");
      tick(2);
      conclude();
   end
endmodule : acquisition_window_vertical_sequencer_tb_top
